// [bcms_pkg.sv]
package bcms_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned I2C_MAX_HZ = 55000;
	// Round the half period up so the bus never runs faster than the limit
	localparam int unsigned I2C_HALF_CYC_INT = (CLK_HZ + 2 * I2C_MAX_HZ - 1) / (2 * I2C_MAX_HZ);
	localparam logic [7:0] I2C_HALF_CYC = 8'(I2C_HALF_CYC_INT);
	localparam logic [3:0] I2C_ACK_BIT = 4'h8;
	localparam logic [6:0] I2C_TARGET_ADDR = 7'h48;
	// ----------------------------------------------------------------
	// Command rates
	// ----------------------------------------------------------------
	localparam logic [31:0] RATE_PINS_HIZ = 32'h0000_2594;
	localparam logic [31:0] RATE_UART_PLAIN = 32'h0000_2595;
	localparam logic [31:0] RATE_UART_HS = 32'h0000_2596;
	localparam logic [31:0] RATE_SUPPLY = 32'h0000_2597;
	localparam logic [31:0] RATE_BOOT_UART = 32'h0000_2581;
	localparam logic [31:0] RATE_BOOT_I2C_A = 32'h0001_86A0;
	localparam logic [31:0] RATE_BOOT_I2C_B = 32'h0001_86A1;
	localparam logic [31:0] RATE_BOOT_I2C_C = 32'h0006_1A80;
	localparam logic [31:0] RATE_BOOT_I2C_D = 32'h0006_1A81;
	localparam logic [31:0] RATE_DEBUGGER = 32'h0000_1F41;
	// Data rates accepted while the UART target_bootloader mode is active
	localparam logic [31:0] BOOT_RATES [8] = '{32'h0000_2580, 32'h0000_3840, 32'h0000_4B00,
		32'h0000_7080, 32'h0000_9600, 32'h0000_DAC0, 32'h0000_E100, 32'h0001_C200};
	// ----------------------------------------------------------------
	// Supply and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] SUPPLY_3V3_MV = 16'h0CE4;
	localparam logic [31:0] RST_RATE = 32'h0000_0000;
	localparam logic RST_FLOW = 1'b0;
	localparam logic RST_UART_EN = 1'b0;
	localparam logic RST_HIZ = 1'b1;
	localparam logic RST_DEBUG_EN = 1'b1;
	localparam logic [7:0] RST_HALF_CNT = 8'h00;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BOOT_NONE = 3'b001,
		BOOT_UART = 3'b010,
		BOOT_I2C = 3'b100
	} bcms_boot_t;
	typedef enum logic [5:0] {
		I_IDLE = 6'b000001,
		I_START = 6'b000010,
		I_LOW = 6'b000100,
		I_HIGH = 6'b001000,
		I_STOPL = 6'b010000,
		I_STOPH = 6'b100000
	} bcms_i2c_st_t;
	typedef struct packed {
		logic uart_en;
		logic flow_en;
		logic parity_even;
		logic [31:0] rate;
	} bcms_uart_cfg_t;
	typedef struct packed {
		logic hiz;
		logic uart;
		logic handshake;
		logic i2c;
	} bcms_pins_t;
endpackage

// [bcms_selector.sv]
// Summary of operation
// - Reserved open rate is taken as mode command
// - Rate 9620 puts all target pins high-Z
// - Rate 9621 selects UART without handshake, default
// - Rate 9622 selects UART with RTS/CTS handshake
// - Rate 9623 sets 3.3 V, then switches through
// - Command rates never become data rates
// - UART stays disabled until a data rate
// - No prior command: 3.3 V, no flow control
// - No flow control in target_bootloader modes
// - UART target_bootloader accepts only listed rates
// - Bootloader frames: 8 data, even parity, 1 stop
// - Device is always I2C master
// - Seven-bit addressing, fixed target address 0x48
// - I2C clock about 55 kHz, never faster
// - I2C entry rates start entry with 3.3 V
// - Rate 9601: 3.3 V, UART entry, debugger off
// - Debugger off until power cycle or 8001
// - Bootloader inactive until an entry rate
// - Pins high-Z until a valid activation
`timescale 1ns/1ns
`default_nettype none
module bcms_selector (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic rate_valid_i,
	input wire logic [31:0] rate_i,
	input wire logic supply_good_i,
	input wire logic i2c_go_i,
	input wire logic i2c_rw_i,
	input wire logic i2c_sda_i,
	output bcms_pkg::bcms_uart_cfg_t uart_cfg_o,
	output bcms_pkg::bcms_pins_t pins_o,
	output logic [15:0] supply_mv_o,
	output logic supply_on_o,
	output logic debug_en_o,
	output logic boot_active_o,
	output logic boot_entry_o,
	output logic i2c_scl_o,
	output logic i2c_scl_oe_o,
	output logic i2c_sda_o,
	output logic i2c_sda_oe_o,
	output logic i2c_done_o,
	output logic i2c_ack_o
);
	import bcms_pkg::*;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic is_i2c_entry;
	logic is_cmd;
	logic boot_rate_ok;
	logic data_ok;
	logic cmd_seen_q;
	bcms_boot_t boot_q;
	logic flow_q;
	logic uart_en_q;
	logic hiz_q;
	logic [31:0] rate_q;
	logic debug_q;
	logic supply_req_q;
	logic supply_on_q;
	logic entry_pend_q;
	logic entry_q;
	logic [1:0] good_sync_q;
	logic [1:0] sda_sync_q;
	bcms_pins_t pins_q;

	assign is_i2c_entry = (rate_i == RATE_BOOT_I2C_A) || (rate_i == RATE_BOOT_I2C_B)
		|| (rate_i == RATE_BOOT_I2C_C) || (rate_i == RATE_BOOT_I2C_D);
	assign is_cmd = (rate_i == RATE_PINS_HIZ) || (rate_i == RATE_UART_PLAIN)
		|| (rate_i == RATE_UART_HS) || (rate_i == RATE_SUPPLY)
		|| (rate_i == RATE_BOOT_UART) || (rate_i == RATE_DEBUGGER)
		|| is_i2c_entry;

	always_comb
	begin
		boot_rate_ok = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (rate_i == BOOT_RATES[i])
			begin
				boot_rate_ok = 1'b1;
			end
		end
	end

	// I2C clock is fixed, so a data rate means nothing in that mode
	assign data_ok = rate_valid_i && !is_cmd
		&& ((boot_q == BOOT_NONE) || ((boot_q == BOOT_UART) && boot_rate_ok));

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			good_sync_q <= 2'b00;
			sda_sync_q <= 2'b11;
		end
		else
		begin
			good_sync_q <= {good_sync_q[0], supply_good_i};
			sda_sync_q <= {sda_sync_q[0], i2c_sda_i};
		end
	end

	// ----------------------------------------------------------------
	// Bootloader and debugger mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			boot_q <= BOOT_NONE;
			debug_q <= RST_DEBUG_EN;
		end
		else if (rate_valid_i)
		begin
			if (rate_i == RATE_BOOT_UART)
			begin
				boot_q <= BOOT_UART;
				debug_q <= 1'b0;
			end
			else if (is_i2c_entry)
			begin
				boot_q <= BOOT_I2C;
				debug_q <= 1'b0;
			end
			else if (rate_i == RATE_DEBUGGER)
			begin
				boot_q <= BOOT_NONE;
				debug_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// UART configuration
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			flow_q <= RST_FLOW;
			uart_en_q <= RST_UART_EN;
			rate_q <= RST_RATE;
			hiz_q <= RST_HIZ;
			cmd_seen_q <= 1'b0;
		end
		else if (rate_valid_i)
		begin
			if (is_cmd)
			begin
				cmd_seen_q <= 1'b1;
			end
			if (rate_i == RATE_PINS_HIZ)
			begin
				hiz_q <= 1'b1;
				uart_en_q <= 1'b0;
			end
			else if (rate_i == RATE_UART_PLAIN)
			begin
				flow_q <= 1'b0;
			end
			else if (rate_i == RATE_UART_HS)
			begin
				flow_q <= 1'b1;
			end
			else if ((rate_i == RATE_BOOT_UART) || is_i2c_entry)
			begin
				flow_q <= 1'b0;
				uart_en_q <= 1'b0;
				hiz_q <= !is_i2c_entry;
			end
			else if (data_ok)
			begin
				rate_q <= rate_i;
				uart_en_q <= 1'b1;
				hiz_q <= 1'b0;
				if (!cmd_seen_q)
				begin
					flow_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Target supply
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			supply_req_q <= 1'b0;
			supply_on_q <= 1'b0;
		end
		else
		begin
			if (rate_valid_i && ((rate_i == RATE_SUPPLY) || (rate_i == RATE_BOOT_UART)
				|| is_i2c_entry || (data_ok && !cmd_seen_q)))
			begin
				supply_req_q <= 1'b1;
			end
			// Switch through only once the regulator reports the level
			supply_on_q <= supply_req_q && good_sync_q[1];
		end
	end

	// Entry pulse waits for the supply, the target must be powered first
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			entry_pend_q <= 1'b0;
			entry_q <= 1'b0;
		end
		else
		begin
			entry_q <= entry_pend_q && supply_on_q;
			if (rate_valid_i && ((rate_i == RATE_BOOT_UART) || is_i2c_entry))
			begin
				entry_pend_q <= 1'b1;
			end
			else if (supply_on_q)
			begin
				entry_pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin roles
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pins_q <= '{hiz: 1'b1, uart: 1'b0, handshake: 1'b0, i2c: 1'b0};
		end
		else
		begin
			pins_q.hiz <= hiz_q;
			pins_q.uart <= !hiz_q && (uart_en_q || (boot_q == BOOT_UART));
			pins_q.handshake <= !hiz_q && uart_en_q && flow_q && (boot_q == BOOT_NONE);
			pins_q.i2c <= !hiz_q && (boot_q == BOOT_I2C);
		end
	end

	assign uart_cfg_o.uart_en = uart_en_q;
	assign uart_cfg_o.flow_en = flow_q && (boot_q == BOOT_NONE);
	assign uart_cfg_o.parity_even = (boot_q == BOOT_UART);
	assign uart_cfg_o.rate = rate_q;
	assign pins_o = pins_q;
	assign supply_mv_o = supply_req_q ? SUPPLY_3V3_MV : 16'h0000;
	assign supply_on_o = supply_on_q;
	assign debug_en_o = debug_q;
	assign boot_active_o = (boot_q != BOOT_NONE);
	assign boot_entry_o = entry_q;

	// ----------------------------------------------------------------
	// I2C master, address phase
	// ----------------------------------------------------------------
	bcms_i2c_st_t ist_q;
	logic [7:0] half_cnt_q;
	logic [3:0] bit_cnt_q;
	logic [8:0] shift_q;
	logic scl_low_q;
	logic sda_low_q;
	logic done_q;
	logic ack_q;
	logic tick;

	assign tick = (half_cnt_q == I2C_HALF_CYC - 8'h01);

	always_ff @(posedge clk_i)
	begin
		if (reset_i || (ist_q == I_IDLE) || tick)
		begin
			half_cnt_q <= RST_HALF_CNT;
		end
		else
		begin
			half_cnt_q <= half_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ist_q <= I_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 9'h1FF;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			done_q <= 1'b0;
			ack_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (ist_q)
				I_IDLE:
				begin
					if (i2c_go_i && pins_q.i2c)
					begin
						shift_q <= {I2C_TARGET_ADDR, i2c_rw_i, 1'b1};
						bit_cnt_q <= 4'h0;
						sda_low_q <= 1'b1;
						ist_q <= I_START;
					end
				end
				I_START:
				begin
					if (tick)
					begin
						scl_low_q <= 1'b1;
						sda_low_q <= !shift_q[8];
						ist_q <= I_LOW;
					end
				end
				I_LOW:
				begin
					if (tick)
					begin
						scl_low_q <= 1'b0;
						ist_q <= I_HIGH;
					end
				end
				I_HIGH:
				begin
					if (tick)
					begin
						scl_low_q <= 1'b1;
						if (bit_cnt_q == I2C_ACK_BIT)
						begin
							ack_q <= !sda_sync_q[1];
							sda_low_q <= 1'b1;
							ist_q <= I_STOPL;
						end
						else
						begin
							shift_q <= {shift_q[7:0], 1'b1};
							sda_low_q <= !shift_q[7];
							bit_cnt_q <= bit_cnt_q + 4'h1;
							ist_q <= I_LOW;
						end
					end
				end
				I_STOPL:
				begin
					if (tick)
					begin
						scl_low_q <= 1'b0;
						ist_q <= I_STOPH;
					end
				end
				I_STOPH:
				begin
					if (tick)
					begin
						sda_low_q <= 1'b0;
						done_q <= 1'b1;
						ist_q <= I_IDLE;
					end
				end
				default:
				begin
					ist_q <= I_IDLE;
				end
			endcase
		end
	end

	// Open drain: enables only pull low, and high-Z role masks them
	assign i2c_scl_o = 1'b0;
	assign i2c_sda_o = 1'b0;
	assign i2c_scl_oe_o = scl_low_q && pins_q.i2c;
	assign i2c_sda_oe_o = sda_low_q && pins_q.i2c;
	assign i2c_done_o = done_q;
	assign i2c_ack_o = ack_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [7:0] scl_age_q;
	always_ff @(posedge clk_i)
	begin
		if (reset_i || (i2c_scl_oe_o != $past(i2c_scl_oe_o)))
		begin
			scl_age_q <= 8'h00;
		end
		else if (scl_age_q != 8'hFF)
		begin
			scl_age_q <= scl_age_q + 8'h01;
		end
	end

	property p_hiz;
		@(posedge clk_i) disable iff (reset_i)
		rate_valid_i && (rate_i == RATE_PINS_HIZ) |=> !uart_cfg_o.uart_en ##1 pins_o.hiz;
	endproperty
	a_hiz: assert property (p_hiz) else $error("pins not high-Z after 9620");

	property p_plain;
		@(posedge clk_i) disable iff (reset_i)
		rate_valid_i && (rate_i == RATE_UART_PLAIN) |=> !uart_cfg_o.flow_en;
	endproperty
	a_plain: assert property (p_plain) else $error("flow control left on after 9621");

	property p_hs;
		@(posedge clk_i) disable iff (reset_i)
		rate_valid_i && (rate_i == RATE_UART_HS) && (boot_q == BOOT_NONE) |=> uart_cfg_o.flow_en;
	endproperty
	a_hs: assert property (p_hs) else $error("handshake not set after 9622");

	property p_cmd_rate;
		@(posedge clk_i) disable iff (reset_i)
		rate_valid_i && is_cmd |=> $stable(uart_cfg_o.rate);
	endproperty
	a_cmd_rate: assert property (p_cmd_rate) else $error("command rate taken as data");

	property p_uart_en;
		@(posedge clk_i) disable iff (reset_i)
		$rose(uart_cfg_o.uart_en) |-> $past(data_ok);
	endproperty
	a_uart_en: assert property (p_uart_en) else $error("UART enabled without data rate");

	property p_boot_flow;
		@(posedge clk_i) disable iff (reset_i)
		boot_active_o |-> !uart_cfg_o.flow_en ##1 !pins_o.handshake;
	endproperty
	a_boot_flow: assert property (p_boot_flow) else $error("flow control in bootloader");

	property p_debug;
		@(posedge clk_i) disable iff (reset_i)
		rate_valid_i && ((rate_i == RATE_BOOT_UART) || is_i2c_entry) |=> !debug_en_o
			##0 (!debug_en_o throughout (!(rate_valid_i && (rate_i == RATE_DEBUGGER)))[*1]);
	endproperty
	a_debug: assert property (p_debug) else $error("debugger on in bootloader");

	property p_supply;
		@(posedge clk_i) disable iff (reset_i)
		supply_on_o |-> (supply_mv_o == SUPPLY_3V3_MV) && $past(good_sync_q[1]);
	endproperty
	a_supply: assert property (p_supply) else $error("supply on before configured");

	property p_scl_slow;
		@(posedge clk_i) disable iff (reset_i)
		(ist_q != I_IDLE) && $changed(i2c_scl_oe_o) && pins_q.i2c
			|-> scl_age_q >= I2C_HALF_CYC - 8'h01;
	endproperty
	a_scl_slow: assert property (p_scl_slow) else $error("I2C clock too fast");
endmodule // bcms_selector
`default_nettype wire

// [bcms_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module bcms_host_model (
	input wire logic clk_i,
	output logic rate_valid_o,
	output logic [31:0] rate_o
);
	import bcms_pkg::*;
	initial
	begin
		rate_valid_o = 1'b0;
		rate_o = 32'h0000_0000;
	end
	// ------------------------------------------------------------
	// Port open
	// ------------------------------------------------------------
	// One pulse per open; the rate itself is the command or data rate
	task automatic open_port(input logic [31:0] rate);
		@(posedge clk_i);
		rate_valid_o <= 1'b1;
		rate_o <= rate;
		@(posedge clk_i);
		rate_valid_o <= 1'b0;
		// Closed port: never leave the last rate showing
		rate_o <= ~rate;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
endmodule // bcms_host_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import bcms_pkg::*;
	logic clk_i, reset_i, supply_good_i, i2c_go_i, i2c_rw_i, i2c_sda_i, ack_drive;
	logic rate_valid_i;
	logic [31:0] rate_i;
	bcms_uart_cfg_t uart_cfg_o;
	bcms_pins_t pins_o;
	logic [15:0] supply_mv_o;
	logic supply_on_o, debug_en_o, boot_active_o, boot_entry_o;
	logic i2c_scl_o, i2c_scl_oe_o, i2c_sda_o, i2c_sda_oe_o, i2c_done_o, i2c_ack_o;
	int failures, check_count;
	// Pulled-up open-drain wire: low if either party pulls
	assign i2c_sda_i = ~(i2c_sda_oe_o | ack_drive);
	bcms_host_model u_host (
		.clk_i(clk_i),
		.rate_valid_o(rate_valid_i),
		.rate_o(rate_i)
	);
	bcms_selector u_dut (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.rate_valid_i(rate_valid_i),
		.rate_i(rate_i),
		.supply_good_i(supply_good_i),
		.i2c_go_i(i2c_go_i),
		.i2c_rw_i(i2c_rw_i),
		.i2c_sda_i(i2c_sda_i),
		.uart_cfg_o(uart_cfg_o),
		.pins_o(pins_o),
		.supply_mv_o(supply_mv_o),
		.supply_on_o(supply_on_o),
		.debug_en_o(debug_en_o),
		.boot_active_o(boot_active_o),
		.boot_entry_o(boot_entry_o),
		.i2c_scl_o(i2c_scl_o),
		.i2c_scl_oe_o(i2c_scl_oe_o),
		.i2c_sda_o(i2c_sda_o),
		.i2c_sda_oe_o(i2c_sda_oe_o),
		.i2c_done_o(i2c_done_o),
		.i2c_ack_o(i2c_ack_o)
	);
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic results();
		$display("Counts: %0d checks, %0d failures", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		reset_i <= 1'b1;
		supply_good_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
	endtask
	// Supply_on is given a bounded time after the regulator reports good
	task automatic wait_entry(input logic want_pulse);
		int t;
		logic seen;
		seen = 1'b0;
		@(posedge clk_i);
		supply_good_i <= 1'b1;
		for (t = 0; t < 12; t++)
		begin
			@(posedge clk_i);
			#1;
			seen = seen | boot_entry_o;
		end
		check(supply_on_o, 1'b1, "supply on");
		check(seen, want_pulse, "entry pulse");
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(uart_cfg_o.uart_en, 1'b0, "uart off");
		check(pins_o, 4'h8, "pins hiz");
		check(debug_en_o, 1'b1, "debug on");
		check(boot_active_o, 1'b0, "boot off");
		$display("test reset done");
	endtask
	task automatic t_default();
		logic seen_oe;
		u_host.open_port(32'h0000_4B00);
		check(uart_cfg_o.uart_en, 1'b1, "uart on");
		check(uart_cfg_o.rate, 32'h0000_4B00, "rate");
		check(uart_cfg_o.flow_en, 1'b0, "no flow");
		check(supply_mv_o, 16'h0CE4, "supply");
		check(pins_o, 4'h4, "pins uart");
		wait_entry(1'b0);
		u_host.open_port(32'h0000_2596);
		check(uart_cfg_o.flow_en, 1'b1, "flow");
		check(uart_cfg_o.rate, 32'h0000_4B00, "cmd not rate");
		check(pins_o, 4'h6, "pins hs");
		u_host.open_port(32'h0000_2595);
		check(uart_cfg_o.flow_en, 1'b0, "no flow");
		check(pins_o, 4'h4, "pins no hs");
		u_host.open_port(32'h0000_2594);
		check(uart_cfg_o.uart_en, 1'b0, "uart off");
		check(pins_o, 4'h8, "pins hiz");
		seen_oe = 1'b0;
		@(posedge clk_i);
		i2c_go_i <= 1'b1;
		@(posedge clk_i);
		i2c_go_i <= 1'b0;
		repeat (400)
		begin
			@(posedge clk_i);
			#1;
			seen_oe = seen_oe | i2c_scl_oe_o | i2c_sda_oe_o | i2c_done_o;
		end
		check(seen_oe, 1'b0, "no i2c outside i2c role");
		$display("test uart modes done");
	endtask
	task automatic t_supply();
		do_reset();
		u_host.open_port(32'h0000_2597);
		check(supply_mv_o, 16'h0CE4, "supply 3v3");
		check(supply_on_o, 1'b0, "not yet on");
		wait_entry(1'b0);
		$display("test supply done");
	endtask
	task automatic t_uart_boot();
		do_reset();
		u_host.open_port(32'h0000_2596);
		u_host.open_port(32'h0000_4B00);
		check(pins_o, 4'h6, "pins hs before boot");
		u_host.open_port(32'h0000_2581);
		check(pins_o.handshake, 1'b0, "no handshake pins in boot");
		check(boot_active_o, 1'b1, "boot");
		check(debug_en_o, 1'b0, "debug off");
		check(uart_cfg_o.parity_even, 1'b1, "even parity");
		check(boot_entry_o, 1'b0, "no entry before supply");
		wait_entry(1'b1);
		u_host.open_port(32'h0000_2596);
		check(uart_cfg_o.flow_en, 1'b0, "no flow in boot");
		u_host.open_port(32'h0000_3840);
		check(uart_cfg_o.rate, 32'h0000_3840, "boot rate");
		u_host.open_port(32'h0000_12C0);
		check(uart_cfg_o.rate, 32'h0000_3840, "bad boot rate");
		check(debug_en_o, 1'b0, "debug stays off");
		u_host.open_port(32'h0000_1F41);
		check(debug_en_o, 1'b1, "debug back");
		check(boot_active_o, 1'b0, "boot left");
		$display("test uart boot done");
	endtask
	// Collects SDA at the first nine SCL releases; the target acks the ninth bit
	task automatic t_i2c_xfer(input logic rw);
		logic [8:0] bits;
		logic scl_prev;
		int n, t, per;
		bits = 9'h000;
		n = 0;
		per = 0;
		scl_prev = 1'b0;
		@(posedge clk_i);
		i2c_rw_i <= rw;
		i2c_go_i <= 1'b1;
		@(posedge clk_i);
		i2c_go_i <= 1'b0;
		for (t = 0; t < 5000 && i2c_done_o !== 1'b1; t++)
		begin
			@(posedge clk_i);
			#1;
			per++;
			if (scl_prev === 1'b1 && i2c_scl_oe_o === 1'b0)
			begin
				if (n < 9)
					bits = {bits[7:0], i2c_sda_i};
				if (n > 0)
					check(per, 2 * I2C_HALF_CYC_INT, "scl period");
				n++;
				per = 0;
			end
			// Target changes SDA only while SCL is low, so no false start or stop
			if (scl_prev === 1'b0 && i2c_scl_oe_o === 1'b1)
				ack_drive = (n == 8);
			scl_prev = i2c_scl_oe_o;
		end
		ack_drive = 1'b0;
		if (i2c_done_o !== 1'b1)
		begin
			failures++;
			$display("Error at %0t: i2c done never came", $time);
		end
		else
		begin
			check(bits, {7'h48, rw, 1'b0}, "address byte");
			check(n, 10, "scl pulses");
			check({i2c_scl_o, i2c_sda_o}, 2'b00, "open drain levels");
			@(posedge clk_i);
			#1;
			check(i2c_ack_o, 1'b1, "ack");
		end
	endtask
	task automatic t_i2c();
		logic [31:0] cmds [4];
		cmds = '{32'h0001_86A0, 32'h0001_86A1, 32'h0006_1A80, 32'h0006_1A81};
		foreach (cmds[i])
		begin
			do_reset();
			u_host.open_port(cmds[i]);
			check(boot_active_o, 1'b1, "i2c boot");
			check(debug_en_o, 1'b0, "debug off");
			check(supply_mv_o, 16'h0CE4, "supply");
			check(pins_o, 4'h1, "pins i2c");
			check(uart_cfg_o.flow_en, 1'b0, "no flow");
		end
		u_host.open_port(32'h0000_4B00);
		check(uart_cfg_o.rate, 32'h0000_0000, "no data rate in i2c boot");
		check(pins_o, 4'h1, "pins stay i2c");
		wait_entry(1'b1);
		t_i2c_xfer(1'b1);
		t_i2c_xfer(1'b0);
		$display("test i2c boot done");
	endtask
	initial
	begin
		failures = 0;
		check_count = 0;
		reset_i = 1'b1;
		supply_good_i = 1'b0;
		i2c_go_i = 1'b0;
		i2c_rw_i = 1'b0;
		ack_drive = 1'b0;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		t_reset();
		t_default();
		t_supply();
		t_uart_boot();
		t_i2c();
		results();
	end
endmodule // testbench
`default_nettype wire
